// ### hdl/vec_mode_ctrl.sv
// Mode, burst, subcarrier and caption control of the video encoder.
//
// Function
// [RULE1] RGB power-down forces RGB converters lowest; resets one.
// [RULE2] Composite power-down forces CVBS, Y, C lowest.
// [RULE3] Invert alternation phase when invert and realtime set.
// [RULE4] Luma gain: 100 IRE, or 92.5 with set-up.
// [RULE5] Software clears PAL select when enabling SECAM.
// [RULE6] Chroma bandwidth: zero enlarged, one standard.
// [RULE7] Standard select: zero NTSC, one PAL alternating.
// [RULE8] Line length: zero 864, one 858 pixels.
// [RULE9] Realtime enable lets decoder stream adjust subcarrier.
// [RULE10] Seven-bit burst amplitude field, reset value 47.
// [RULE11] Software picks recommended burst amplitude per standard.
// [RULE12] SECAM uses fixed burst, ignores programmed field.
// [RULE13] Increment built from four bytes, low first.
// [RULE14] Software computes increment as rounded frequency ratio.
// [RULE15] Caption byte sent LSB first after framing.
// [RULE16] Software puts caption parity in the MSB.
// [RULE17] Accumulate increment each pixel clock; phase from top.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module vec_mode_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_rtc_valid,
  input wire logic [31:0] i_rtc_increment,
  input wire logic [vec_pkg::DAC_W-1:0] i_red_code,
  input wire logic [vec_pkg::DAC_W-1:0] i_green_code,
  input wire logic [vec_pkg::DAC_W-1:0] i_blue_code,
  input wire logic [vec_pkg::DAC_W-1:0] i_cvbs_code,
  input wire logic [vec_pkg::DAC_W-1:0] i_luma_code,
  input wire logic [vec_pkg::DAC_W-1:0] i_chroma_code,
  input wire logic i_caption_start,
  input wire logic i_caption_bit_tick,
  output logic [vec_pkg::DAC_W-1:0] o_red_code,
  output logic [vec_pkg::DAC_W-1:0] o_green_code,
  output logic [vec_pkg::DAC_W-1:0] o_blue_code,
  output logic [vec_pkg::DAC_W-1:0] o_cvbs_code,
  output logic [vec_pkg::DAC_W-1:0] o_luma_code,
  output logic [vec_pkg::DAC_W-1:0] o_chroma_code,
  output vec_pkg::vec_standard_t o_standard,
  output logic o_v_alternate,
  output logic o_chroma_wide_band,
  output logic [9:0] o_luma_swing_x10,
  output logic [9:0] o_black_setup_x10,
  output logic [6:0] o_burst_amplitude,
  output logic o_line_start,
  output logic [7:0] o_subcarrier_phase,
  output logic o_caption_bit,
  output logic o_caption_active
);
  import vec_pkg::*;

  // Software-visible registers.
  logic [7:0] std_q; // Encoder standard control.
  logic [7:0] burst_q; // Burst amplitude and realtime enable.
  logic [31:0] inc_q; // Subcarrier increment, four bytes.
  logic [7:0] caption_q; // First odd-field caption byte.

  // Bus handshake state.
  logic ack_q; // High in the cycle the answer is presented.
  logic [7:0] idx; // Register index from the byte address.
  logic aligned; // Address is word aligned.
  logic wr_commit; // Write takes effect at this edge.

  // Realtime increment from the external decoder.
  logic [31:0] rtc_inc_q;
  logic rtc_seen_q; // A realtime value has arrived since enable.
  logic [31:0] eff_inc; // Increment fed to the accumulator.

  // Line timing and alternation.
  logic [9:0] pix_cnt_q;
  logic [9:0] line_len;
  logic line_end;
  logic alt_q; // Nominal alternation phase, toggles each line.

  // Accumulator phase from the submodule.
  logic [31:0] acc_phase;

  // Caption serializer state.
  logic [7:0] cap_shift_q;
  logic [3:0] cap_cnt_q;

  // Serializer states.
  typedef enum logic {
    CAP_IDLE,
    CAP_SEND
  } vec_cap_state_t;
  vec_cap_state_t cap_state_q;

  // Read mux value for a register index.
  function automatic logic [7:0] reg_read(input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      REG_STD_IDX: v = std_q;
      REG_BURST_IDX: v = burst_q;
      REG_INC0_IDX: v = inc_q[7:0];
      REG_INC1_IDX: v = inc_q[15:8];
      REG_INC2_IDX: v = inc_q[23:16];
      REG_INC3_IDX: v = inc_q[31:24];
      REG_CAPTION_IDX: v = caption_q;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Drives a converter to its lowest code while powered down.
  function automatic logic [DAC_W-1:0] gate_dac(input logic pd, input logic [DAC_W-1:0] code);
    return pd ? DAC_LOWEST : code;
  endfunction

  // Address decode; unaligned accesses are treated as unmapped.
  assign idx = i_avs_address[9:2];
  assign aligned = (i_avs_address[1:0] == 2'h0);

  // A write lands only at the edge where waitrequest is seen low.
  assign wr_commit = i_avs_write && ack_q && aligned && i_avs_byteenable[0];

  // Waitrequest rises by default; it drops for exactly one cycle per
  // request, which gives a fixed one-wait-state answer.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_q <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else if (ack_q) begin
      // Answer taken by the master at this edge; withdraw it.
      ack_q <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else if (i_avs_read || i_avs_write) begin
      ack_q <= 1'b1;
      o_avs_waitrequest <= 1'b0;
    end
  end

  // Read data is captured with the answer and held until the next one.
  // Unmapped addresses read as zero; upper bits always read as zero.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (!ack_q && i_avs_read) begin
      o_avs_readdata <= {24'h00_0000, aligned ? reg_read(idx) : 8'h00};
    end
  end

  // Standard control register. Software is trusted to clear the PAL
  // select when it enables SECAM; the hardware does not fix it up, so a
  // conflicting setting simply lets SECAM take precedence below.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      std_q <= STD_RESET; // [RULE1]
    end else if (wr_commit && idx == REG_STD_IDX) begin
      std_q <= i_avs_writedata[7:0];
    end
  end

  // Burst amplitude and realtime enable register.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      burst_q <= BURST_RESET; // [RULE10]
    end else if (wr_commit && idx == REG_BURST_IDX) begin
      burst_q <= i_avs_writedata[7:0];
    end
  end

  // Increment bytes, lowest at the first index, highest at the last.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      inc_q <= INC_RESET;
    end else if (wr_commit) begin
      if (idx == REG_INC0_IDX) begin
        inc_q[7:0] <= i_avs_writedata[7:0]; // [RULE13]
      end
      if (idx == REG_INC1_IDX) begin
        inc_q[15:8] <= i_avs_writedata[7:0]; // [RULE13]
      end
      if (idx == REG_INC2_IDX) begin
        inc_q[23:16] <= i_avs_writedata[7:0]; // [RULE13]
      end
      if (idx == REG_INC3_IDX) begin
        inc_q[31:24] <= i_avs_writedata[7:0]; // [RULE13]
      end
    end
  end

  // Caption byte; parity in the MSB is the writer's job.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      caption_q <= CAPTION_RESET;
    end else if (wr_commit && idx == REG_CAPTION_IDX) begin
      caption_q <= i_avs_writedata[7:0]; // [RULE16]
    end
  end

  // Latest realtime increment from the decoder stream. The flag drops
  // when the enable goes off so stale values never resurface later.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rtc_inc_q <= INC_RESET;
      rtc_seen_q <= 1'b0;
    end else if (!burst_q[BIT_RTC_EN]) begin
      rtc_seen_q <= 1'b0;
    end else if (i_rtc_valid) begin
      rtc_inc_q <= i_rtc_increment;
      rtc_seen_q <= 1'b1;
    end
  end

  // Realtime value overrides the programmed one while enabled.
  assign eff_inc = (burst_q[BIT_RTC_EN] && rtc_seen_q) ? rtc_inc_q : inc_q; // [RULE9]

  // Direct digital synthesizer for the subcarrier.
  vec_phase_acc u_phase_acc (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_increment(eff_inc),
    .i_phase_clear(1'b0),
    .o_phase(acc_phase)
  );

  // Subcarrier phase from the accumulator's top byte.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_subcarrier_phase <= 8'h00;
    end else begin
      o_subcarrier_phase <= acc_phase[31:24]; // [RULE17]
    end
  end

  // Line length chosen by software.
  assign line_len = std_q[BIT_LINE_LEN] ? LINE_LEN_SHORT : LINE_LEN_LONG; // [RULE8]
  // Compare with >= so a shortened line mid-count still wraps at once.
  assign line_end = (pix_cnt_q >= line_len - 10'h001);

  // Pixel counter and one-cycle line start marker.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pix_cnt_q <= 10'h000;
      o_line_start <= 1'b0;
    end else begin
      pix_cnt_q <= line_end ? 10'h000 : pix_cnt_q + 10'h001; // [RULE8]
      o_line_start <= line_end;
    end
  end

  // Nominal alternation toggles once per line.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      alt_q <= 1'b0;
    end else if (line_end) begin
      alt_q <= ~alt_q;
    end
  end

  // V alternation: off for NTSC, line-alternating for PAL, and inverted
  // only when realtime control is enabled as well as the invert bit.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_v_alternate <= 1'b0;
    end else if (!std_q[BIT_PAL] || std_q[BIT_SECAM]) begin
      o_v_alternate <= 1'b0; // [RULE7]
    end else begin
      o_v_alternate <= alt_q ^ (std_q[BIT_ALT_INV] && burst_q[BIT_RTC_EN]); // [RULE3]
    end
  end

  // Colour standard; SECAM wins if software left PAL set.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_standard <= STD_PAL;
    end else if (std_q[BIT_SECAM]) begin
      o_standard <= STD_SECAM; // [RULE5]
    end else begin
      o_standard <= std_q[BIT_PAL] ? STD_PAL : STD_NTSC; // [RULE7]
    end
  end

  // Chroma bandwidth and luma gain controls.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_chroma_wide_band <= 1'b0;
      o_luma_swing_x10 <= SWING_FULL_X10;
      o_black_setup_x10 <= SETUP_NONE_X10;
    end else begin
      o_chroma_wide_band <= ~std_q[BIT_CHROMA_BW]; // [RULE6]
      if (std_q[BIT_LUMA_GAIN]) begin
        o_luma_swing_x10 <= SWING_REDUCED_X10; // [RULE4]
        o_black_setup_x10 <= SETUP_BLACK_X10; // [RULE4]
      end else begin
        o_luma_swing_x10 <= SWING_FULL_X10; // [RULE4]
        o_black_setup_x10 <= SETUP_NONE_X10; // [RULE4]
      end
    end
  end

  // Burst amplitude; SECAM uses a fixed value regardless of the field.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_burst_amplitude <= BURST_RESET[6:0];
    end else if (std_q[BIT_SECAM]) begin
      o_burst_amplitude <= SECAM_BURST_AMP; // [RULE12]
    end else begin
      o_burst_amplitude <= burst_q[BURST_MSB:0]; // [RULE10]
    end
  end

  // Converter outputs, forced to the lowest code when powered down.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_red_code <= DAC_LOWEST;
      o_green_code <= DAC_LOWEST;
      o_blue_code <= DAC_LOWEST;
      o_cvbs_code <= DAC_LOWEST;
      o_luma_code <= DAC_LOWEST;
      o_chroma_code <= DAC_LOWEST;
    end else begin
      o_red_code <= gate_dac(std_q[BIT_RGB_PD], i_red_code); // [RULE1]
      o_green_code <= gate_dac(std_q[BIT_RGB_PD], i_green_code); // [RULE1]
      o_blue_code <= gate_dac(std_q[BIT_RGB_PD], i_blue_code); // [RULE1]
      o_cvbs_code <= gate_dac(std_q[BIT_COMP_PD], i_cvbs_code); // [RULE2]
      o_luma_code <= gate_dac(std_q[BIT_COMP_PD], i_luma_code); // [RULE2]
      o_chroma_code <= gate_dac(std_q[BIT_COMP_PD], i_chroma_code); // [RULE2]
    end
  end

  // Caption serializer. The byte is copied at start so a register write
  // during the line cannot tear the bits already on the wire.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cap_state_q <= CAP_IDLE;
      cap_shift_q <= 8'h00;
      cap_cnt_q <= 4'h0;
      o_caption_bit <= 1'b0;
      o_caption_active <= 1'b0;
    end else begin
      unique case (cap_state_q)
        CAP_IDLE: begin
          o_caption_bit <= 1'b0;
          o_caption_active <= 1'b0;
          if (i_caption_start) begin
            // First bit out is the LSB, right after the framing code.
            cap_state_q <= CAP_SEND;
            cap_shift_q <= {1'b0, caption_q[7:1]}; // [RULE15]
            o_caption_bit <= caption_q[0]; // [RULE15]
            o_caption_active <= 1'b1;
            cap_cnt_q <= 4'h1;
          end
        end
        CAP_SEND: begin
          if (i_caption_bit_tick) begin
            if (cap_cnt_q == CAPTION_BITS) begin
              cap_state_q <= CAP_IDLE;
              o_caption_bit <= 1'b0;
              o_caption_active <= 1'b0;
            end else begin
              o_caption_bit <= cap_shift_q[0]; // [RULE15]
              cap_shift_q <= {1'b0, cap_shift_q[7:1]};
              cap_cnt_q <= cap_cnt_q + 4'h1;
            end
          end
        end
      endcase
    end
  end
endmodule

// ### hdl/vec_phase_acc.sv
// Subcarrier phase accumulator of the direct digital synthesizer.
`timescale 1ns/1ps
module vec_phase_acc (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [31:0] i_increment,
  input wire logic i_phase_clear,
  output logic [31:0] o_phase
);
  import vec_pkg::*;

  // Phase register; wraps naturally modulo two to the thirty-second.
  logic [31:0] phase_q;
  logic [31:0] phase_d;

  // Next phase adds the increment once per pixel clock.
  always_comb begin
    phase_d = phase_q + i_increment;
    if (i_phase_clear) begin
      phase_d = 32'h0000_0000;
    end
  end

  // Accumulate on every pixel clock.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= 32'h0000_0000;
    end else begin
      phase_q <= phase_d; // [RULE17]
    end
  end

  assign o_phase = phase_q;
endmodule

// ### hdl/vec_pkg.sv
// Shared constants and types for the video encoder mode and subcarrier block.
package vec_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] REG_STD_IDX = 8'h61;
  localparam logic [7:0] REG_BURST_IDX = 8'h62;
  localparam logic [7:0] REG_INC0_IDX = 8'h63;
  localparam logic [7:0] REG_INC1_IDX = 8'h64;
  localparam logic [7:0] REG_INC2_IDX = 8'h65;
  localparam logic [7:0] REG_INC3_IDX = 8'h66;
  localparam logic [7:0] REG_CAPTION_IDX = 8'h67;
  // Bit positions in encoder_standard_control.
  localparam int BIT_RGB_PD = 7;
  localparam int BIT_COMP_PD = 6;
  localparam int BIT_ALT_INV = 5;
  localparam int BIT_LUMA_GAIN = 4;
  localparam int BIT_SECAM = 3;
  localparam int BIT_CHROMA_BW = 2;
  localparam int BIT_PAL = 1;
  localparam int BIT_LINE_LEN = 0;
  // Bit positions in burst_and_realtime_control.
  localparam int BIT_RTC_EN = 7;
  localparam int BURST_MSB = 6;
  // Values after reset.
  localparam logic [7:0] STD_RESET = 8'h86;
  localparam logic [7:0] BURST_RESET = 8'h2f;
  localparam logic [31:0] INC_RESET = 32'h0000_0000;
  localparam logic [7:0] CAPTION_RESET = 8'h00;
  // Fixed burst amplitude used while SECAM encoding is active.
  localparam logic [6:0] SECAM_BURST_AMP = 7'h2f;
  // Pixel clocks per line.
  localparam logic [9:0] LINE_LEN_LONG = 10'h360;
  localparam logic [9:0] LINE_LEN_SHORT = 10'h35a;
  // Luma swing and black set-up in tenths of an IRE unit.
  localparam logic [9:0] SWING_FULL_X10 = 10'h3e8;
  localparam logic [9:0] SWING_REDUCED_X10 = 10'h39d;
  localparam logic [9:0] SETUP_NONE_X10 = 10'h000;
  localparam logic [9:0] SETUP_BLACK_X10 = 10'h04b;
  // Converter code width and its lowest code.
  localparam int DAC_W = 10;
  localparam logic [9:0] DAC_LOWEST = 10'h000;
  // Bits in one caption byte.
  localparam logic [3:0] CAPTION_BITS = 4'h8;
  // Colour standard produced by the encoder.
  typedef enum logic [1:0] {
    STD_NTSC,
    STD_PAL,
    STD_SECAM
  } vec_standard_t;
endpackage

// ### sim/vec_mode_ctrl_assertions.sv
// Concurrent checks on the ports of the video encoder mode control block.
`timescale 1ns/1ps
module vec_mode_checker
  import vec_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [31:0] o_avs_readdata,
  input wire logic [9:0] i_green_code,
  input wire logic [9:0] i_luma_code,
  input wire logic [9:0] o_red_code,
  input wire logic [9:0] o_green_code,
  input wire logic [9:0] o_cvbs_code,
  input wire logic [9:0] o_luma_code,
  input wire vec_standard_t o_standard,
  input wire logic o_v_alternate,
  input wire logic [9:0] o_luma_swing_x10,
  input wire logic [9:0] o_black_setup_x10,
  input wire logic [6:0] o_burst_amplitude,
  input wire logic o_line_start,
  input wire logic i_caption_start,
  input wire logic o_caption_active
);
  // All checks share the pixel clock and its reset.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [9:0] gap_q; // Clocks since the last line start.
  logic seen_q; // A first line start has been seen.
  // Line gap counter; the first line after reset starts at an arbitrary point, so it is skipped.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_q <= 10'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= o_line_start ? 10'h001 : gap_q + 10'h001;
      seen_q <= seen_q | o_line_start;
    end
  end
  a_rgb_gate: assert property (o_red_code != 10'h000 |-> o_green_code == $past(i_green_code))
    else $error("RGB converters not gated together");
  a_comp_gate: assert property (o_cvbs_code != 10'h000 |-> o_luma_code == $past(i_luma_code))
    else $error("Composite converters not gated together");
  a_gain_pair: assert property (o_luma_swing_x10 == SWING_FULL_X10 ? o_black_setup_x10 == SETUP_NONE_X10 :
    (o_luma_swing_x10 == SWING_REDUCED_X10 && o_black_setup_x10 == SETUP_BLACK_X10))
    else $error("Luma swing and set-up disagree");
  a_secam_burst: assert property (o_standard == STD_SECAM |-> o_burst_amplitude == SECAM_BURST_AMP)
    else $error("Burst not fixed in SECAM");
  a_ntsc_steady: assert property (o_standard != STD_PAL && $past(o_standard) != STD_PAL |-> !o_v_alternate)
    else $error("V alternates outside PAL");
  a_line_length: assert property (o_line_start && seen_q |-> gap_q == LINE_LEN_LONG || gap_q == LINE_LEN_SHORT)
    else $error("Line length wrong");
  a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("Bus request not answered after one wait state");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("Wait request low too long");
  a_read_upper: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("Read data upper bytes not zero");
  a_caption_start: assert property ($rose(o_caption_active) |-> $past(i_caption_start))
    else $error("Caption started without start pulse");
  // Main scenarios reached.
  c_line: cover property (o_line_start && seen_q);
  c_secam: cover property (o_standard == STD_SECAM);
  c_caption: cover property ($rose(o_caption_active));
endmodule

// ### sim/video_encoder_mode_subcarrier_control_bench.sv
// Self-checking bench for the video encoder mode and subcarrier control block.
`timescale 1ns/1ps
module video_encoder_mode_subcarrier_control_bench;
  import vec_pkg::*;
  logic clk = 1'b0; // Pixel clock.
  logic rstn = 1'b0; // Active-low reset.
  logic [9:0] addr = 10'h000; // Bus request fields, held until answered.
  logic rd = 1'b0, wr = 1'b0;
  logic [31:0] wdata = 32'h0, got, rdd;
  logic [3:0] be = 4'h0;
  logic rtcv = 1'b0, cstart = 1'b0, tick = 1'b0; // Side-band pulses.
  logic [31:0] rtci = 32'h0400_0000; // Realtime increment, distinct from the programmed one.
  logic [9:0] red = 10'h0, grn = 10'h0, blu = 10'h0, cvb = 10'h0, lum = 10'h0, chr = 10'h0;
  logic [9:0] o_red, o_grn, o_blu, o_cvb, o_lum, o_chr, swing, setup;
  vec_standard_t std_o;
  logic waitq, valt, wide, lstart, cbit, cact, v0, v1;
  logic [6:0] burst;
  logic [7:0] phase, v;
  int err_total = 0, tests_run = 0, n;
  logic [7:0] idx_t [7] = '{REG_STD_IDX, REG_BURST_IDX, REG_INC0_IDX, REG_INC1_IDX, REG_INC2_IDX,
    REG_INC3_IDX, REG_CAPTION_IDX};
  logic [7:0] rst_t [7] = '{STD_RESET, BURST_RESET, INC_RESET[7:0], INC_RESET[15:8], INC_RESET[23:16],
    INC_RESET[31:24], CAPTION_RESET};
  logic [7:0] mode_t [6] = '{8'h00, 8'h52, 8'h84, 8'h08, 8'h3c, 8'h40};

  vec_mode_ctrl dut (.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdd),
    .o_avs_waitrequest(waitq), .i_rtc_valid(rtcv), .i_rtc_increment(rtci), .i_red_code(red),
    .i_green_code(grn), .i_blue_code(blu), .i_cvbs_code(cvb), .i_luma_code(lum), .i_chroma_code(chr),
    .i_caption_start(cstart), .i_caption_bit_tick(tick), .o_red_code(o_red), .o_green_code(o_grn),
    .o_blue_code(o_blu), .o_cvbs_code(o_cvb), .o_luma_code(o_lum), .o_chroma_code(o_chr),
    .o_standard(std_o), .o_v_alternate(valt), .o_chroma_wide_band(wide), .o_luma_swing_x10(swing),
    .o_black_setup_x10(setup), .o_burst_amplitude(burst), .o_line_start(lstart),
    .o_subcarrier_phase(phase), .o_caption_bit(cbit), .o_caption_active(cact));

  // Free-running pixel clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One bus cycle; the request stands until wait request is sampled low, then data is taken.
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] e);
    int k;
    k = 0;
    // One idle edge first, so a release and the next request never share a time step.
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    be <= e;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (waitq !== 1'b0 && k < 100);
    if (waitq !== 1'b0) err_total++;
    got = rdd;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, {i, 2'b00}, d, 4'hf);
  endtask

  // Reads one byte address and compares the low byte, upper bytes must be zero.
  task automatic rreg(input logic [9:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(got, {24'h0, exp});
  endtask

  // Phase advance over two clocks, after the settings have settled.
  task automatic phase_step(output logic [7:0] d);
    logic [7:0] p0;
    repeat (4) @(posedge clk);
    p0 = phase;
    repeat (2) @(posedge clk);
    d = phase - p0;
  endtask

  task automatic rtc_pulse();
    rtcv <= 1'b1;
    @(posedge clk);
    rtcv <= 1'b0;
  endtask

  // Measures one whole line and samples the V sign early in two successive lines.
  task automatic line_len(output int len, output logic a, output logic b);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (lstart !== 1'b1 && k < 2000);
    len = 0;
    do begin
      @(posedge clk);
      len++;
      if (len == 10) a = valt;
    end while (lstart !== 1'b1 && len < 2000);
    repeat (10) @(posedge clk);
    b = valt;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need well under ten thousand clocks.
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset values, then write and read back every register.
    for (int i = 0; i < 7; i++) rreg({idx_t[i], 2'b00}, rst_t[i]);
    for (int i = 0; i < 7; i++) begin
      wreg(idx_t[i], 8'h90 + 8'(i));
      rreg({idx_t[i], 2'b00}, 8'h90 + 8'(i));
    end
    // Byte lane off changes nothing; an unmapped place ignores a write and reads zero; an unaligned place reads zero.
    bus(1'b1, {REG_BURST_IDX, 2'b00}, 8'h11, 4'h0);
    rreg({REG_BURST_IDX, 2'b00}, 8'h91);
    bus(1'b1, 10'h000, 8'h77, 4'hf);
    rreg(10'h000, 8'h00);
    rreg({REG_STD_IDX, 2'b01}, 8'h00);
    wreg(REG_BURST_IDX, 8'h43);
    // Every mode bit combination of interest, converters fed a code that tracks the mode.
    // SECAM settings always leave the PAL select clear, as software must.
    for (int i = 0; i < 6; i++) begin
      v = mode_t[i];
      {red, grn, blu, cvb, lum, chr} <= {6{v, 2'b01}};
      wreg(REG_STD_IDX, v);
      repeat (3) @(posedge clk);
      chk(o_red, v[7] ? 10'h000 : {v, 2'b01});
      chk(o_grn, v[7] ? 10'h000 : {v, 2'b01});
      chk(o_blu, v[7] ? 10'h000 : {v, 2'b01});
      chk(o_cvb, v[6] ? 10'h000 : {v, 2'b01});
      chk(o_lum, v[6] ? 10'h000 : {v, 2'b01});
      chk(o_chr, v[6] ? 10'h000 : {v, 2'b01});
      chk(swing, v[4] ? SWING_REDUCED_X10 : SWING_FULL_X10);
      chk(setup, v[4] ? SETUP_BLACK_X10 : SETUP_NONE_X10);
      chk(wide, !v[2]);
      chk(std_o, v[3] ? STD_SECAM : (v[1] ? STD_PAL : STD_NTSC));
      chk(burst, v[3] ? SECAM_BURST_AMP : 7'h43);
    end
    // Increment 0x0180_0000 built byte by byte gives three phase steps per two clocks.
    wreg(REG_INC0_IDX, 8'h00);
    wreg(REG_INC1_IDX, 8'h00);
    wreg(REG_INC2_IDX, 8'h80);
    wreg(REG_INC3_IDX, 8'h01);
    phase_step(v);
    chk(v, 8'h03);
    rtc_pulse();
    phase_step(v);
    chk(v, 8'h03);
    wreg(REG_BURST_IDX, 8'hc3);
    rtc_pulse();
    phase_step(v);
    chk(v, 8'h08);
    wreg(REG_BURST_IDX, 8'h43);
    phase_step(v);
    chk(v, 8'h03);
    // Long PAL lines alternate V; short NTSC lines do not.
    wreg(REG_STD_IDX, 8'h02);
    line_len(n, v0, v1);
    chk(n, 32'd864);
    chk(v1, !v0);
    // Early in the same line, the invert bit with realtime enabled flips the V sign.
    wreg(REG_BURST_IDX, 8'hc3);
    v0 = valt;
    wreg(REG_STD_IDX, 8'h22);
    repeat (3) @(posedge clk);
    chk(valt, !v0);
    wreg(REG_STD_IDX, 8'h01);
    line_len(n, v0, v1);
    chk(n, 32'd858);
    chk({v0, v1}, 2'b00);
    // Caption byte goes out least significant bit first; its MSB holds odd parity.
    wreg(REG_CAPTION_IDX, 8'hb5);
    cstart <= 1'b1;
    @(posedge clk);
    cstart <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      chk({cact, cbit}, {1'b1, 1'(8'hb5 >> i)});
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    @(posedge clk);
    chk(cact, 1'b0);
    print_verdict();
  end
endmodule

bind vec_mode_ctrl vec_mode_checker u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
  .i_green_code(i_green_code), .i_luma_code(i_luma_code), .o_red_code(o_red_code), .o_green_code(o_green_code),
  .o_cvbs_code(o_cvbs_code), .o_luma_code(o_luma_code), .o_standard(o_standard), .o_v_alternate(o_v_alternate),
  .o_luma_swing_x10(o_luma_swing_x10), .o_black_setup_x10(o_black_setup_x10),
  .o_burst_amplitude(o_burst_amplitude), .o_line_start(o_line_start), .i_caption_start(i_caption_start),
  .o_caption_active(o_caption_active));
